// file: common/aux_b_step5_pkg.sv
// package: register map, field layout and decode types for step-five config
package aux_b_step5_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] STEP5_CFG_INDEX  = 32'h0000_00D5;
  localparam logic [31:0] STEP5_CFG_ADDR   = 32'h0000_0354; // index times four
  localparam logic [15:0] STEP5_CFG_RESET  = 16'h0005;
  localparam logic [15:0] STEP5_CFG_WMASK  = 16'hE01F;      // reserved 12:5 not stored

  // ==========================================================
  // field positions
  localparam int ENABLE_POS   = 15;
  localparam int GAIN_HI      = 14;
  localparam int GAIN_LO      = 13;
  localparam int NEG_POS      = 4;
  localparam int POS_HI       = 3;
  localparam int POS_LO       = 0;

  // ==========================================================
  // positive select codes
  localparam logic [3:0] POS_EXT_LAST     = 4'h7;
  localparam logic [3:0] POS_TEMP_B       = 4'h8;
  localparam logic [3:0] POS_SHORT_GND    = 4'h9;
  localparam logic [3:0] POS_TEST_DAC_A   = 4'hA;
  localparam logic [3:0] POS_ANALOG_Q     = 4'hB;
  localparam logic [3:0] POS_IO_Q         = 4'hC;
  localparam logic [3:0] POS_HALF_MON     = 4'hD;
  localparam logic [3:0] POS_ANALOG_POWER_INPUT_DIV     = 4'hE;
  localparam logic [3:0] POS_DIGITAL_POWER_INPUT_DIV     = 4'hF;

  // gain multiplier as a plain factor
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;

  // negative input source
  typedef enum logic [1:0] {
    NEG_GROUND   = 2'b00,
    NEG_EXT_SEVN = 2'b01,
    NEG_AUTO     = 2'b10
  } neg_src_e;

  // decoded step settings as seen by the sequencer
  typedef struct packed {
    logic       enable;
    logic [2:0] gain;
    logic       pos_internal;
    logic [3:0] pos_code;
    logic [7:0] pos_onehot_ext;
    neg_src_e   neg_src;
  } step_cfg_s;

endpackage

// file: rtl/step5_decode.sv
// step-five decode: turns stored fields into sequencer settings
`timescale 1ns/1ps
`default_nettype none
module step5_decode
  import aux_b_step5_pkg::*;
(
  // stored fields
  input  wire logic [15:0] i_cfg,
  // decoded settings
  output step_cfg_s        o_cfg
);

  // ==========================================================
  // field decode
  wire logic [1:0] gain_code = i_cfg[GAIN_HI:GAIN_LO];
  wire logic [3:0] pos_code  = i_cfg[POS_HI:POS_LO];
  wire logic       internal  = (pos_code > POS_EXT_LAST);
  wire logic       neg_bit   = i_cfg[NEG_POS];

  // 00 -> 1, 01 -> 2, 10 and 11 -> 4
  assign o_cfg.gain = (gain_code == 2'h0) ? GAIN_X1 :
                      (gain_code == 2'h1) ? GAIN_X2 : GAIN_X4;
  assign o_cfg.enable       = i_cfg[ENABLE_POS];
  assign o_cfg.pos_internal = internal;
  assign o_cfg.pos_code     = pos_code;
  // internal sources override the negative bit
  assign o_cfg.neg_src = internal ? NEG_AUTO :
                         (neg_bit ? NEG_EXT_SEVN : NEG_GROUND);

  // external input one-hot, empty for internal codes
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ext
      assign o_cfg.pos_onehot_ext[g] = !internal && (pos_code[2:0] == 3'(g));
    end
  endgenerate

endmodule
`default_nettype wire

// file: rtl/aux_b_step5_cfg.sv
// step-five configuration register of converter B sequencer, apb slave
//
// How it works
// - bit 15 enables step five
// - bits 14:13 gain 1, 2, 4, 4
// - bits 12:5 always read zero
// - bit 4 negative: ground or input seven
// - codes 0-7 pick external inputs 0-7
// - codes 8-F pick internal sources
// - internal codes ignore the negative bit
// - register at D5h resets to 0005h
`timescale 1ns/1ps
`default_nettype none
module aux_b_step5_cfg
  import aux_b_step5_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // decoded step settings
  output logic             o_step_enable,
  output logic      [2:0]  o_step_gain,
  output logic      [3:0]  o_pos_code,
  output logic             o_pos_internal,
  output logic      [7:0]  o_pos_ext_onehot,
  output logic      [1:0]  o_neg_src
);

  // ==========================================================
  // state
  logic [15:0] cfg_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  step_cfg_s   dec_ff;
  step_cfg_s   dec_w;

  // ==========================================================
  // bus decode
  wire logic        setup    = i_psel && !i_penable;
  wire logic        hit      = (i_paddr == STEP5_CFG_ADDR);
  wire logic        wr_take  = i_psel && i_penable && pready_ff && i_pwrite && hit;
  wire logic [15:0] lane_msk = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}} & STEP5_CFG_WMASK;
  wire logic [15:0] nxt_cfg  = (cfg_ff & ~lane_msk) | (i_pwdata[15:0] & lane_msk);
  wire logic [15:0] rd_view  = cfg_ff & STEP5_CFG_WMASK;

  // ==========================================================
  // stored configuration
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg_ff <= STEP5_CFG_RESET;
    end else if (wr_take) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ==========================================================
  // apb answer: ready one cycle after setup, data registered
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !hit;
      prdata_ff  <= (setup && hit && !i_pwrite) ? {16'h0000, rd_view} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // decode and register outputs
  step5_decode u_decode (
    .i_cfg (cfg_ff),
    .o_cfg (dec_w)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dec_ff <= '{enable: 1'b0, gain: GAIN_X1, pos_internal: 1'b0,
                  pos_code: 4'h5, pos_onehot_ext: 8'h20, neg_src: NEG_GROUND};
    end else begin
      dec_ff <= dec_w;
    end
  end

  assign o_prdata         = prdata_ff;
  assign o_pready         = pready_ff;
  assign o_pslverr        = pslverr_ff;
  assign o_step_enable    = dec_ff.enable;
  assign o_step_gain      = dec_ff.gain;
  assign o_pos_code       = dec_ff.pos_code;
  assign o_pos_internal   = dec_ff.pos_internal;
  assign o_pos_ext_onehot = dec_ff.pos_onehot_ext;
  assign o_neg_src        = dec_ff.neg_src;

  // ==========================================================
  // checks
  sequence s_write_hit;
    wr_take;
  endsequence

  a_reserved_reads_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pready |-> o_prdata[31:5] == 27'h0 || o_prdata[31:16] == 16'h0 && o_prdata[12:5] == 8'h0)
    else $error("reserved bits read nonzero");

  a_reserved_not_stored: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cfg_ff[12:5] == 8'h00)
    else $error("reserved bits stored");

  a_enable_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_write_hit and i_pstrb[1]) |=> ##1 o_step_enable == $past(i_pwdata[15], 2))
    else $error("enable output wrong");

  a_gain_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 o_step_gain == (($past(cfg_ff[14:13]) == 2'h0) ? 3'h1 :
                        ($past(cfg_ff[14:13]) == 2'h1) ? 3'h2 : 3'h4))
    else $error("gain map wrong");

  a_neg_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 !$past(cfg_ff[3]) |-> o_neg_src == ($past(cfg_ff[4]) ? 2'b01 : 2'b00))
    else $error("negative select wrong");

  a_ext_onehot: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 !$past(cfg_ff[3]) |-> o_pos_ext_onehot == (8'h01 << $past(cfg_ff[2:0])))
    else $error("external select wrong");

  a_internal_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pos_internal |-> o_pos_ext_onehot == 8'h00 && o_pos_code[3])
    else $error("internal code decode wrong");

  a_neg_auto: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pos_internal |-> o_neg_src == 2'b10)
    else $error("auto negative missing");

  a_reset_value: assert property (@(posedge i_core_clk)
    $fell(i_rst) |-> cfg_ff == STEP5_CFG_RESET)
    else $error("reset value wrong");

  // ==========================================================
  // bus phase sequences
  sequence s_setup;
    i_psel && !i_penable;
  endsequence

  sequence s_access;
    i_psel && i_penable;
  endsequence

  sequence s_read_hit;
    i_psel && !i_penable && !i_pwrite && hit;
  endsequence

  sequence s_setup_miss;
    i_psel && !i_penable && !hit;
  endsequence

  // setup, then access carrying the answer
  sequence s_full_xfer;
    s_setup ##1 (s_access and o_pready);
  endsequence

  // ==========================================================
  // bus answer checks
  // answer in the cycle after setup
  a_ready_after_setup: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_setup |=> o_pready)
    else $error("ready missing after setup");

  // ready drops once the access is done
  a_ready_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_full_xfer |=> !o_pready)
    else $error("ready held too long");

  // ready only ever follows a setup cycle
  a_ready_after_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pready |-> $past(i_psel) && !$past(i_penable))
    else $error("ready without setup");

  // error flag only rides on the answer
  a_err_with_ready: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pslverr |-> o_pready)
    else $error("error flag without ready");

  // unmapped address answers with error
  a_err_on_miss: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_setup_miss |=> o_pslverr)
    else $error("error flag missing");

  // mapped address answers clean
  a_no_err_on_hit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_setup and hit) |=> !o_pslverr)
    else $error("error flag on mapped address");

  // refused transfers return no data
  a_err_no_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("data on refused transfer");

  // read returns the stored word
  a_read_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_hit |=> o_prdata == {16'h0000, $past(cfg_ff)})
    else $error("read data wrong");

  // upper half of the word reads zero
  a_upper_read_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("upper half nonzero");

  // data bus quiet outside the answer
  a_idle_data_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_pready |-> o_prdata == 32'h0000_0000)
    else $error("data outside answer");

  // writes return no data
  a_write_no_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_setup and i_pwrite) |=> o_prdata == 32'h0000_0000)
    else $error("data on write");

  // ==========================================================
  // store checks
  // low lane takes the written bits
  a_low_lane_lands: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_write_hit and i_pstrb[0]) |=> cfg_ff[4:0] == $past(i_pwdata[4:0]))
    else $error("low lane not stored");

  // high lane takes the written bits
  a_high_lane_lands: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_write_hit and i_pstrb[1]) |=> cfg_ff[15:13] == $past(i_pwdata[15:13]))
    else $error("high lane not stored");

  // unstrobed low lane untouched
  a_low_lane_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_write_hit and !i_pstrb[0]) |=> $stable(cfg_ff[4:0]))
    else $error("low lane changed");

  // unstrobed high lane untouched
  a_high_lane_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_write_hit and !i_pstrb[1]) |=> $stable(cfg_ff[15:13]))
    else $error("high lane changed");

  // nothing but a write changes the word
  a_idle_no_store: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !wr_take |=> $stable(cfg_ff))
    else $error("word changed without write");

  // unmapped access leaves the word alone
  a_miss_no_store: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_access and !hit) |=> $stable(cfg_ff))
    else $error("unmapped access stored");

  // reads leave the word alone
  a_read_no_store: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_access and !i_pwrite) |=> $stable(cfg_ff))
    else $error("read changed word");

  // ==========================================================
  // decode checks
  // enable follows the word one clock later
  a_enable_lag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 o_step_enable == $past(cfg_ff[15]))
    else $error("enable lag wrong");

  // positive code follows the word
  a_code_lag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 o_pos_code == $past(cfg_ff[3:0]))
    else $error("positive code lag wrong");

  // internal flag follows the top code bit
  a_internal_lag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ##1 o_pos_internal == $past(cfg_ff[3]))
    else $error("internal flag lag wrong");

  // gain factor is one of three values
  a_gain_legal: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_step_gain == 3'h1 || o_step_gain == 3'h2 || o_step_gain == 3'h4)
    else $error("gain factor illegal");

  // exactly one external input on
  a_onehot_ext: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_pos_internal |-> $onehot(o_pos_ext_onehot))
    else $error("external select not one-hot");

  // the lit input matches the code
  a_hot_matches: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_pos_internal |-> o_pos_ext_onehot[o_pos_code[2:0]])
    else $error("external select mismatch");

  // external codes never pick automatic negative
  a_ext_no_auto: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_pos_internal |-> o_neg_src != 2'b10)
    else $error("automatic negative on external");

  // negative source code never unused value
  a_neg_legal: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_neg_src != 2'b11)
    else $error("negative source illegal");

  // settings hold while the word holds
  a_settings_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $stable(cfg_ff) |=> $stable(o_step_gain) && $stable(o_neg_src))
    else $error("settings moved");

  // ==========================================================
  // reset checks
  // decoded outputs show the reset word
  a_reset_outputs: assert property (@(posedge i_core_clk)
    $fell(i_rst) |-> !o_step_enable && o_step_gain == 3'h1 && o_pos_code == 4'h5 &&
                     o_pos_ext_onehot == 8'h20 && o_neg_src == 2'b00)
    else $error("reset outputs wrong");

  // bus answer quiet after reset
  a_reset_quiet: assert property (@(posedge i_core_clk)
    i_rst |=> !o_pready && !o_pslverr && o_prdata == 32'h0000_0000)
    else $error("bus not quiet after reset");

endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// testbench: apb driven checks of the step-five configuration register
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import aux_b_step5_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         s_en;
  wire  [2:0]  s_gain;
  wire  [3:0]  s_pos;
  wire         s_int;
  wire  [7:0]  s_hot;
  wire  [1:0]  s_neg;
  int          errors;
  int          checked;
  int          cyc;
  logic [15:0] mreg;
  logic [31:0] d;
  logic [31:0] rd;
  logic        er;

  aux_b_step5_cfg dut (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_step_enable(s_en), .o_step_gain(s_gain),
    .o_pos_code(s_pos), .o_pos_internal(s_int), .o_pos_ext_onehot(s_hot), .o_neg_src(s_neg)
  );

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one apb transfer, model update and answer checks
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= wd; pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (w && a === STEP5_CFG_ADDR) begin
      if (s[0]) mreg[7:0] = wd[7:0];
      if (s[1]) mreg[15:8] = wd[15:8];
      mreg = mreg & 16'hE01F;
    end
    chk(er, a !== STEP5_CFG_ADDR, "error flag");
    if (!w) chk(rd, a === STEP5_CFG_ADDR ? {16'h0000, mreg} : 32'h0, "read data");
  endtask

  // decoded outputs against the model, one lag cycle allowed
  task automatic dec_chk;
    repeat (2) @(posedge clk);
    #1;
    chk(s_en, mreg[15], "enable");
    chk(s_gain, mreg[14:13] == 2'b00 ? GAIN_X1 : (mreg[14] ? GAIN_X4 : GAIN_X2), "gain");
    chk(s_pos, mreg[3:0], "pos code");
    chk(s_int, mreg[3], "internal");
    chk(s_hot, mreg[3] ? 8'h00 : 8'h01 << mreg[2:0], "onehot");
    chk(s_neg, mreg[3] ? NEG_AUTO : {1'b0, mreg[4]}, "neg src");
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; pstrb = 0;
    errors = 0; checked = 0; cyc = 0; mreg = 16'h0005;
    void'($urandom(96140));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    dec_chk();
    xfer(1'b0, STEP5_CFG_ADDR, $urandom, 4'hF);
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      d = $urandom;
      d[3:0] = k[3:0];
      xfer(1'b1, STEP5_CFG_ADDR, d, {2'($urandom % 4), 2'b11});
      dec_chk();
      xfer(1'b0, STEP5_CFG_ADDR, 32'h0, 4'h0);
    end
    $display("test all codes done");
    xfer(1'b1, STEP5_CFG_ADDR, 32'h0000_FFFF, 4'b0001);
    xfer(1'b0, STEP5_CFG_ADDR, 32'h0, 4'h0);
    $display("test byte strobe done");
    xfer(1'b1, STEP5_CFG_INDEX, 32'h0000_FFFF, 4'hF);
    xfer(1'b1, STEP5_CFG_ADDR + 32'h4, 32'h0000_FFFF, 4'hF);
    xfer(1'b0, STEP5_CFG_ADDR + 32'h4, 32'h0, 4'h0);
    xfer(1'b0, STEP5_CFG_ADDR, 32'h0, 4'h0);
    $display("test unmapped done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mreg = 16'h0005;
    dec_chk();
    xfer(1'b0, STEP5_CFG_ADDR, 32'h0, 4'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
